//--- bench/alu_status_flags_tb.sv
// Testbench for the ALU status flag block: Avalon register tasks and directed cases.
// Assumes the slave answers in its own time and all byte lanes enabled.
`timescale 1ns/1ps
`include "alu_flags_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module alu_status_flags_tb import alu_flags_pkg::*;;
	// ==========================================================
	// Signals and counters.
	logic        clk_i         = 1'b0;  // Core clock, 100 ns period.
	logic        reset_n_i     = 1'b0;  // Active low reset.
	logic        clk_en_i      = 1'b1;  // Dropped once to check that the block freezes.
	logic        ext_set       = 1'b0;  // Extended-set bit sent with every command.
	logic [3:0]  address_i     = 4'h0;  // Register byte address.
	logic        read_i        = 1'b0;  // Read request.
	logic        write_i       = 1'b0;  // Write request.
	logic [31:0] writedata_i   = 32'h0000_0000;
	logic [3:0]  byteenable_i  = 4'hF;  // All lanes, partial writes are not tested.
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic [7:0]  flags_o;
	logic        mode_error_o;
	int          err_total     = 0;     // Mismatches.
	int          check_count   = 0;     // Comparisons made.
	int          cyc           = 0;     // Cycles run, for the hang guard.
	logic [31:0] q;                     // Last read word.
	logic [12:0] e;                     // Expected flags and result.
	alu_op_t     ar_op [5]  = '{OP_ADD_ACC_REG, OP_ADD_LIT_ACC, OP_LIT_MINUS_ACC, OP_REG_MINUS_ACC, OP_REG_MINUS_ACC};
	logic [7:0]  ar_acc [5] = '{8'h7F, 8'hFF, 8'h05, 8'h01, 8'h01};
	logic [7:0]  ar_src [5] = '{8'h01, 8'h01, 8'h05, 8'h00, 8'h80};
	alu_op_t     ft_op [8]  = '{OP_CLEAR_REG, OP_CLEAR_REG, OP_BIT_SET, OP_BIT_RESET, OP_NIBBLE_SWAP,
		OP_REG_TO_REG, OP_ACC_TO_REG, OP_ADD_ACC_REG};
	logic [7:0]  ft_pre [8] = '{8'h1B, 8'h0A, 8'h00, 8'h1F, 8'h03, 8'h15, 8'h00, 8'h01};
	logic [7:0]  ft_lit [8] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  ft_acc [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hEA, 8'hFF};
	logic [7:0]  ft_exp [8] = '{8'h1F, 8'h0E, 8'h10, 8'h1E, 8'h10, 8'h15, 8'h0A, 8'h07};

	alu_status_flags dut_u (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .flags_o(flags_o), .mode_error_o(mode_error_o)
	);

	// ==========================================================
	// Clock and hang guard; the ceiling is far above the few hundred cycles the tests need.
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			final_report();
		end
	end

	// ==========================================================
	// Bus tasks. The request is held until waitrequest is seen low at a rising edge.
	task automatic bus_xfer(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
		address_i   <= a;
		writedata_i <= d;
		read_i      <= !wr;
		write_i     <= wr;
		do begin
			@(posedge clk_i);
		end while (waitrequest_o !== 1'b0);
		r = readdata_o;
		read_i  <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus_xfer
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus_xfer(a, 1'b1, d, r);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] r);
		bus_xfer(a, 1'b0, 32'h0000_0000, r);
	endtask : rd
	task automatic cmd(input logic [3:0] op, input logic tgt, input logic dst, input logic [4:0] md,
		input logic [7:0] lit);
		wr(`REG_COMMAND, {8'h00, lit, 2'b00, ext_set, md, 2'b00, tgt, dst, op});
	endtask : cmd
	// A rotate through carry from a known carry into the operand register.
	task automatic rot_case(input logic [7:0] pre, input logic [3:0] op, input logic [7:0] s,
		input logic [7:0] res, input logic [1:0] fl);
		wr(`REG_FLAGS, {24'h00_0000, pre});
		wr(`REG_OPERAND, {24'h00_0000, s});
		cmd(op, 1'b0, 1'b1, AM_DIRECT, 8'h00);
		rd(`REG_RESULT, q);
		`CHK("rotate result", res, q[7:0])
		rd(`REG_FLAGS, q);
		`CHK("rotate carries", fl, q[1:0])
	endtask : rot_case

	// Reference sum with the five flags, worked out independently of the design.
	function automatic logic [12:0] calc(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		calc = {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
	endfunction : calc

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		`CHK("flags after reset", 8'h00, flags_o)
		wr(`REG_FLAGS, 32'h0000_00FF);
		rd(`REG_FLAGS, q);
		`CHK("flags top bits", 32'h0000_001F, q)
		`CHK("flags port", 8'h1F, flags_o)
		rd(4'h2, q);
		`CHK("unmapped read", 32'h0000_0000, q)
		// Add and subtract, both destinations; subtraction adds the two's complement.
		for (int i = 0; i < 5; i++) begin
			wr(`REG_OPERAND, {16'h0000, ar_acc[i], ar_src[i]});
			cmd(ar_op[i], 1'b0, i[0], AM_DIRECT, ar_src[i]);
			e = (ar_op[i] == OP_LIT_MINUS_ACC || ar_op[i] == OP_REG_MINUS_ACC) ?
				calc(ar_src[i], ~ar_acc[i], 1'b1) : calc(ar_acc[i], ar_src[i], 1'b0);
			rd(`REG_RESULT, q);
			`CHK("arith result", e[7:0], q[7:0])
			rd(`REG_FLAGS, q);
			`CHK("arith flags", {3'b000, e[12:8]}, q[7:0])
			`CHK("arith flags port", {3'b000, e[12:8]}, flags_o)
			rd(`REG_OPERAND, q);
			`CHK("arith dest", e[7:0], i[0] ? q[7:0] : q[15:8])
		end
		// A logic operation giving zero sets zero and clears negative.
		wr(`REG_OPERAND, 32'h0000_F00F);
		cmd(OP_AND_ACC_REG, 1'b0, 1'b0, AM_DIRECT, 8'h00);
		rd(`REG_FLAGS, q);
		`CHK("logic zero", 8'h04, q[7:0] & 8'h14)
		rot_case(8'h01, OP_ROT_RIGHT, 8'h11, 8'h88, 2'b11);
		rot_case(8'h00, OP_ROT_LEFT, 8'h90, 8'h20, 2'b01);
		// The flag register as destination of clear, bit, swap, move and add operations.
		for (int i = 0; i < 8; i++) begin
			wr(`REG_FLAGS, {24'h00_0000, ft_pre[i]});
			wr(`REG_OPERAND, {16'h0000, ft_acc[i], 8'h00});
			cmd(ft_op[i], 1'b1, 1'b1, AM_DIRECT, ft_lit[i]);
			rd(`REG_FLAGS, q);
			`CHK("flag target", {24'h00_0000, ft_exp[i]}, q)
		end
		// Indexed mode is refused while the extended set is off.
		cmd(OP_REG_TO_REG, 1'b0, 1'b0, AM_INDEXED, 8'h00);
		`CHK("indexed refused", 1'b1, mode_error_o)
		// With it on every one-hot mode is legal; an empty mode field is refused without effect.
		ext_set = 1'b1;
		for (int j = 0; j < 5; j++) begin
			cmd(OP_REG_TO_REG, 1'b0, 1'b0, 5'h01 << j, 8'h00);
			`CHK("mode legal", 1'b0, mode_error_o)
		end
		wr(`REG_FLAGS, 32'h0000_0000);
		cmd(OP_CLEAR_REG, 1'b1, 1'b1, 5'h00, 8'h00);
		`CHK("mode refused", 1'b1, mode_error_o)
		rd(`REG_RESULT, q);
		`CHK("mode error bit", 1'b1, q[8])
		`CHK("refused no effect", 8'h00, flags_o)
		// A frozen block holds its state and stalls the master until enabled again.
		clk_en_i <= 1'b0;
		fork
			wr(`REG_FLAGS, 32'h0000_000A);
			begin
				repeat (6) @(posedge clk_i);
				`CHK("frozen flags", 8'h00, flags_o)
				`CHK("frozen wait", 1'b1, waitrequest_o)
				clk_en_i <= 1'b1;
			end
		join
		`CHK("thawed flags", 8'h0A, flags_o)
		final_report();
	end
endmodule : alu_status_flags_tb

//--- common/alu_flags_defines.svh
// Constants for the ALU status flag block: flag positions, register offsets, command fields, masks.
// Assumes inclusion by bare name from the testbench and the design files.
`ifndef ALU_FLAGS_DEFINES_SVH
`define ALU_FLAGS_DEFINES_SVH
// ==========================================================
// Flag positions inside the flag register.
`define FLG_CARRY     0
`define FLG_HALF      1
`define FLG_ZERO      2
`define FLG_SIGNED    3
`define FLG_NEG       4
`define FLG_IMPL_MASK 8'h1F
`define FLG_RESET     8'h00
// ==========================================================
// Avalon register offsets (byte addresses, word aligned).
`define REG_FLAGS     4'h0
`define REG_OPERAND   4'h4
`define REG_COMMAND   4'h8
`define REG_RESULT    4'hC
// ==========================================================
// Command field layout in the command register.
`define CMD_OP_LSB    0
`define CMD_DEST_BIT  4
`define CMD_TGT_BIT   5
`define CMD_MODE_LSB  8
// The extended-set bit sits apart from the mode field, so an indexed request can really be refused.
`define CMD_EXT_SET_BIT 13
`define CMD_LIT_LSB   16
`endif

//--- common/alu_flags_pkg.sv
// Types shared by the ALU status flag block.
// Assumes the defines header is on the include path.
package alu_flags_pkg;
	// ==========================================================
	// Operations understood by the flag engine.
	typedef enum logic [3:0] {
		OP_ADD_ACC_REG   = 4'h0,
		OP_ADD_LIT_ACC   = 4'h1,
		OP_LIT_MINUS_ACC = 4'h2,
		OP_REG_MINUS_ACC = 4'h3,
		OP_ROT_RIGHT     = 4'h4,
		OP_ROT_LEFT      = 4'h5,
		OP_CLEAR_REG     = 4'h6,
		OP_BIT_RESET     = 4'h7,
		OP_BIT_SET       = 4'h8,
		OP_NIBBLE_SWAP   = 4'h9,
		OP_REG_TO_REG    = 4'hA,
		OP_ACC_TO_REG    = 4'hB,
		OP_AND_ACC_REG   = 4'hC
	} alu_op_t;
	// Data addressing modes, one-hot.
	typedef enum logic [4:0] {
		AM_INHERENT = 5'h01,
		AM_LITERAL  = 5'h02,
		AM_DIRECT   = 5'h04,
		AM_INDIRECT = 5'h08,
		AM_INDEXED  = 5'h10
	} addr_mode_t;
	// Bus slave state, one-hot.
	typedef enum logic [2:0] {
		BS_IDLE = 3'h1,
		BS_EXEC = 3'h2,
		BS_DONE = 3'h4
	} bus_state_t;
endpackage : alu_flags_pkg

//--- common/alu_op_if.sv
// Carrier between the top and the flag engine: one operation and its outcome.
// Assumes one clock domain; purely combinational inside the engine.
`timescale 1ns/1ps
interface alu_op_if;
	import alu_flags_pkg::*;
	alu_op_t    op;        // Operation.
	logic [7:0] acc;       // Accumulator operand.
	logic [7:0] src;       // Register or literal operand.
	logic [7:0] bit_mask;  // One-hot bit for bit set/reset.
	logic [7:0] flags_in;  // Current flags.
	logic [7:0] result;    // Computed result.
	logic [7:0] flags_out; // New flags from the operation.
	logic       touches;   // Operation affects arithmetic flags.
	modport engine (input op, acc, src, bit_mask, flags_in, output result, flags_out, touches);
	modport user   (output op, acc, src, bit_mask, flags_in, input result, flags_out, touches);
endinterface : alu_op_if

//--- hw/alu_flag_engine.sv
// Combinational ALU and status flag computation for one operation.
// Assumes the caller routes results into the flag register.
`timescale 1ns/1ps
`include "alu_flags_defines.svh"
module alu_flag_engine
	import alu_flags_pkg::*;
(
	// Operation channel.
	alu_op_if.engine io
);
	// ==========================================================
	// Adder shared by add and subtract; subtract adds the two's complement.
	logic [8:0] sum;   // Full sum with carry out.
	logic [4:0] low;   // Low nibble sum with carry out.
	logic [7:0] a_opd; // First adder input.
	logic [7:0] b_opd; // Second adder input.
	logic       cin;   // Carry in, one for subtraction.

	always_comb begin
		io.result    = io.src;
		io.flags_out = io.flags_in & `FLG_IMPL_MASK;
		io.touches   = 1'b0;
		a_opd        = io.src;
		b_opd        = io.acc;
		cin          = 1'b0;
		if (io.op == OP_LIT_MINUS_ACC || io.op == OP_REG_MINUS_ACC) begin
			b_opd = ~io.acc; // RULE_05
			cin   = 1'b1;
		end
		sum = {1'b0, a_opd} + {1'b0, b_opd} + {8'h00, cin};
		low = {1'b0, a_opd[3:0]} + {1'b0, b_opd[3:0]} + {4'h0, cin};
		unique case (io.op)
			OP_ADD_ACC_REG, OP_ADD_LIT_ACC, OP_LIT_MINUS_ACC, OP_REG_MINUS_ACC: begin
				io.result                 = sum[7:0];
				io.touches                = 1'b1;
				// Carry flags read as not-borrow after subtraction.
				io.flags_out[`FLG_CARRY]  = sum[8];  // RULE_11
				io.flags_out[`FLG_HALF]   = low[4];  // RULE_10
				io.flags_out[`FLG_SIGNED] = (a_opd[7] == b_opd[7]) && (sum[7] != a_opd[7]); // RULE_08
				io.flags_out[`FLG_NEG]    = sum[7];  // RULE_07
				io.flags_out[`FLG_ZERO]   = (sum[7:0] == 8'h00); // RULE_09
			end
			OP_AND_ACC_REG: begin
				io.result                = io.src & io.acc;
				io.touches               = 1'b1;
				io.flags_out[`FLG_NEG]   = io.result[7];
				io.flags_out[`FLG_ZERO]  = (io.result == 8'h00); // RULE_09
			end
			OP_ROT_RIGHT: begin
				io.result                = {io.flags_in[`FLG_CARRY], io.src[7:1]};
				io.touches               = 1'b1;
				io.flags_out[`FLG_CARRY] = io.src[0]; // RULE_13
				io.flags_out[`FLG_HALF]  = io.src[4]; // RULE_12
			end
			OP_ROT_LEFT: begin
				io.result                = {io.src[6:0], io.flags_in[`FLG_CARRY]};
				io.touches               = 1'b1;
				io.flags_out[`FLG_CARRY] = io.src[7]; // RULE_13
				io.flags_out[`FLG_HALF]  = io.src[3]; // RULE_12
			end
			OP_CLEAR_REG: begin
				io.result               = 8'h00;
				io.touches              = 1'b1;
				io.flags_out[`FLG_ZERO] = 1'b1; // RULE_03
			end
			// These leave all arithmetic flags alone.
			OP_BIT_RESET: io.result = io.src & ~io.bit_mask; // RULE_04
			OP_BIT_SET:   io.result = io.src | io.bit_mask;  // RULE_04
			OP_NIBBLE_SWAP: io.result = {io.src[3:0], io.src[7:4]}; // RULE_04
			OP_REG_TO_REG: io.result = io.src; // RULE_04
			OP_ACC_TO_REG: io.result = io.acc; // RULE_04
			default: io.result = io.src;
		endcase
	end
endmodule : alu_flag_engine

//--- hw/alu_mode_decode.sv
// Addressing mode legality check for the requested data operand mode.
// Assumes the mode code arrives one-hot from the command register.
`timescale 1ns/1ps
module alu_mode_decode
	import alu_flags_pkg::*;
(
	// Request.
	input  wire logic [4:0] mode_i,
	input  wire logic       ext_set_i,
	// Verdict.
	output logic            legal_o
);
	// ==========================================================
	// Four base modes always; indexed only with the extended set on.
	always_comb begin
		unique case (mode_i)
			AM_INHERENT, AM_LITERAL, AM_DIRECT, AM_INDIRECT: legal_o = 1'b1; // RULE_14
			AM_INDEXED:  legal_o = ext_set_i; // RULE_15
			default:     legal_o = 1'b0;
		endcase
	end
endmodule : alu_mode_decode

//--- hw/alu_status_flags.sv
// Top of the ALU status flag block with its Avalon-MM register slave.
// Assumes a synchronous Avalon master on clk_i; one access at a time.
//
// Behaviour
// [RULE_01] Flag register usable as any instruction operand.
// [RULE_02] Flag-affecting op on flags: flags win.
// [RULE_03] Clearing flags sets only zero flag.
// [RULE_04] Bit, swap, move ops write flags directly.
// [RULE_05] Subtract adds two's complement; borrow inverted.
// [RULE_06] Top three flag bits read zero.
// [RULE_07] Negative flag follows result MSB.
// [RULE_08] Signed overflow flag on sign corruption.
// [RULE_09] Zero flag set when result zero.
// [RULE_10] Half carry from bit three.
// [RULE_11] Carry out of MSB.
// [RULE_12] Rotate loads half carry from bit four/three.
// [RULE_13] Rotate loads carry from end bit.
// [RULE_14] Four base addressing modes supported.
// [RULE_15] Indexed mode only with extended set.
`timescale 1ns/1ps
`include "alu_flags_defines.svh"
module alu_status_flags
	import alu_flags_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	// Avalon-MM slave.
	input  wire logic [3:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// Status.
	output logic      [7:0]  flags_o,
	output logic             mode_error_o
);
	// ==========================================================
	// Whole state in one struct.
	typedef struct packed {
		bus_state_t  st;       // Bus handshake state.
		logic [7:0]  flags;    // Flag register, bits 4:0 live.
		logic [7:0]  acc;      // Accumulator.
		logic [7:0]  operand;  // Register file operand.
		logic [7:0]  result;   // Last result.
		logic [31:0] rdata;    // Read data.
		logic        wait_r;   // Wait request.
		logic        mode_err; // Last command used illegal mode.
	} state_t;
	state_t s_r;   // Registered state.
	state_t s_nxt; // Next state.

	logic [31:0] cmd_w;  // Command word under write.
	logic        legal;  // Mode verdict.
	alu_op_if    op_ch(); // Engine channel.

	// ==========================================================
	// Leaf instances.
	alu_flag_engine u_engine (
		.io (op_ch.engine)
	);
	alu_mode_decode u_mode (
		.mode_i    (cmd_w[`CMD_MODE_LSB +: 5]),
		.ext_set_i (cmd_w[`CMD_EXT_SET_BIT]),
		.legal_o   (legal)
	);

	// Command decode feeds the engine straight from the bus.
	always_comb begin
		cmd_w          = writedata_i;
		op_ch.op       = alu_op_t'(cmd_w[`CMD_OP_LSB +: 4]);
		op_ch.acc      = s_r.acc;
		// Flag register as source when the target bit points at it.
		op_ch.src      = cmd_w[`CMD_TGT_BIT] ? (s_r.flags & `FLG_IMPL_MASK) : s_r.operand; // RULE_01
		if (op_ch.op == OP_ADD_LIT_ACC || op_ch.op == OP_LIT_MINUS_ACC) begin
			op_ch.src = cmd_w[`CMD_LIT_LSB +: 8];
		end
		op_ch.bit_mask = 8'h01 << cmd_w[`CMD_LIT_LSB +: 3];
		op_ch.flags_in = s_r.flags;
	end

	// ==========================================================
	// Next-state logic: bus decode and command execution.
	// The slave answers in a fixed three-cycle pattern so the master sees
	// two wait cycles per access; this keeps the read mux registered.
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			BS_IDLE: begin
				s_nxt.wait_r = 1'b1;
				if (read_i || write_i) begin
					s_nxt.st = BS_EXEC;
				end
			end
			BS_EXEC: begin
				s_nxt.st     = BS_DONE;
				s_nxt.wait_r = 1'b0;
				s_nxt.rdata  = 32'h0000_0000;
				if (read_i) begin
					unique case (address_i)
						`REG_FLAGS:   s_nxt.rdata = {24'h00_0000, s_r.flags & `FLG_IMPL_MASK}; // RULE_06
						`REG_OPERAND: s_nxt.rdata = {16'h0000, s_r.acc, s_r.operand};
						`REG_RESULT:  s_nxt.rdata = {23'h00_0000, s_r.mode_err, s_r.result};
						default:      s_nxt.rdata = 32'h0000_0000;
					endcase
				end else if (write_i) begin
					unique case (address_i)
						`REG_FLAGS: if (byteenable_i[0]) begin
							s_nxt.flags = writedata_i[7:0] & `FLG_IMPL_MASK; // RULE_06
						end
						`REG_OPERAND: begin
							if (byteenable_i[0]) s_nxt.operand = writedata_i[7:0];
							if (byteenable_i[1]) s_nxt.acc = writedata_i[15:8];
						end
						`REG_COMMAND: begin
							s_nxt.mode_err = ~legal; // RULE_15
							if (legal) begin
								s_nxt.result = op_ch.result;
								s_nxt.flags  = op_ch.flags_out;
								if (cmd_w[`CMD_TGT_BIT] && !op_ch.touches) begin
									s_nxt.flags = op_ch.result & `FLG_IMPL_MASK; // RULE_04
								end else if (cmd_w[`CMD_TGT_BIT]) begin
									s_nxt.flags = op_ch.flags_out; // RULE_02
								end else if (cmd_w[`CMD_DEST_BIT]) begin
									s_nxt.operand = op_ch.result;
								end else begin
									s_nxt.acc = op_ch.result;
								end
							end
						end
						default: s_nxt.flags = s_r.flags;
					endcase
				end
			end
			BS_DONE: begin
				s_nxt.st     = BS_IDLE;
				s_nxt.wait_r = 1'b1;
			end
			default: begin
				s_nxt.st     = BS_IDLE;
				s_nxt.wait_r = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// State register with clock enable.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r        <= '0;
			s_r.st     <= BS_IDLE;
			s_r.wait_r <= 1'b1;
			s_r.flags  <= `FLG_RESET;
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops.
	assign readdata_o    = s_r.rdata;
	assign waitrequest_o = s_r.wait_r;
	assign flags_o       = s_r.flags;
	assign mode_error_o  = s_r.mode_err;

	// ==========================================================
	// Checks.
	upper_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_06
		flags_o[7:5] == 3'b000) else $error("upper flag bits not zero");
	wait_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		clk_en_i && !waitrequest_o |=> waitrequest_o) else $error("waitrequest low too long");
	clear_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_03
		clk_en_i && s_r.st == BS_EXEC && write_i && address_i == `REG_COMMAND && legal
		&& writedata_i[3:0] == 4'h6 |=> flags_o[`FLG_ZERO]) else $error("clear missed zero flag");
	// Indexed mode with the extended set off must be refused.
	idx_mode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_15
		clk_en_i && s_r.st == BS_EXEC && write_i && address_i == `REG_COMMAND
		&& writedata_i[`CMD_MODE_LSB +: 5] == AM_INDEXED && !writedata_i[`CMD_EXT_SET_BIT]
		|=> mode_error_o) else $error("indexed accepted");
	neg_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
		clk_en_i && s_r.st == BS_EXEC && write_i && address_i == `REG_COMMAND && legal
		&& writedata_i[3:0] == 4'h0 |=> flags_o[`FLG_NEG] == s_r.result[7]) else $error("negative flag wrong");
	zero_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_09
		clk_en_i && s_r.st == BS_EXEC && write_i && address_i == `REG_COMMAND && legal
		&& writedata_i[3:0] == 4'h1 |=> flags_o[`FLG_ZERO] == (s_r.result == 8'h00)) else $error("zero flag wrong");
	sub_carry_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_05
		clk_en_i && s_r.st == BS_EXEC && write_i && address_i == `REG_COMMAND && legal
		&& writedata_i[3:0] == 4'h3 && !writedata_i[5]
		|=> flags_o[`FLG_CARRY] == ($past(s_r.operand) >= $past(s_r.acc))) else $error("borrow wrong");
	rot_left_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12 RULE_13
		clk_en_i && s_r.st == BS_EXEC && write_i && address_i == `REG_COMMAND && legal
		&& writedata_i[3:0] == 4'h5 && !writedata_i[5]
		|=> flags_o[`FLG_CARRY] == $past(s_r.operand[7]) && flags_o[`FLG_HALF] == $past(s_r.operand[3]))
		else $error("rotate flags wrong");
	read_done_c: cover property (@(posedge clk_i) read_i && !waitrequest_o);
	write_done_c: cover property (@(posedge clk_i) write_i && !waitrequest_o);
	mode_err_c: cover property (@(posedge clk_i) $rose(mode_error_o));
endmodule : alu_status_flags
